// *** common/tmr_pkg.sv ***
// Purpose: shared constants and types for the dual counter/timer block
// Assumes: 10 MHz system clock, 32-bit APB register window
// Notes:   each register sits in the low byte of one aligned word
package tmr_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_CLKSEL  = 8'h08;
	localparam logic [7:0] OFS_INCFG   = 8'h0C;
	localparam logic [7:0] OFS_T0_LOW  = 8'h10;
	localparam logic [7:0] OFS_T0_HIGH = 8'h14;
	localparam logic [7:0] OFS_T1_LOW  = 8'h18;
	localparam logic [7:0] OFS_T1_HIGH = 8'h1C;

	// reset value shared by every register
	localparam logic [7:0] REG_RESET = 8'h00;

	// control register fields
	localparam int unsigned TF1_BIT = 7;
	localparam int unsigned TR1_BIT = 6;
	localparam int unsigned TF0_BIT = 5;
	localparam int unsigned TR0_BIT = 4;

	// mode register fields
	localparam int unsigned T0_MODE_LSB = 0;
	localparam int unsigned CT0_BIT     = 2;
	localparam int unsigned TIMER_ZERO_GATE_BIT_BIT   = 3;
	localparam int unsigned T1_MODE_LSB = 4;
	localparam int unsigned CT1_BIT     = 6;
	localparam int unsigned GATE1_BIT   = 7;

	// clock select and input config fields, with writable masks
	localparam int unsigned SCALE_LSB    = 0;
	localparam int unsigned T0_CLK_BIT   = 3;
	localparam int unsigned T1_CLK_BIT   = 4;
	localparam logic [7:0]  CLKSEL_MASK  = 8'h1B;
	localparam int unsigned POL0_BIT     = 0;
	localparam int unsigned POL1_BIT     = 1;
	localparam logic [7:0]  INCFG_MASK   = 8'h03;

	// prescaler divisors per scale code
	localparam logic [5:0] DIV_CODE0 = 6'd12;
	localparam logic [5:0] DIV_CODE1 = 6'd4;
	localparam logic [5:0] DIV_CODE2 = 6'd48;
	localparam logic [5:0] DIV_CODE3 = 6'd12;

	typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} timer_mode_t;
endpackage : tmr_pkg

// *** common/prescale_if.sv ***
// Purpose: carries the scale choice to the prescaler and its tick back
// Assumes: both ends on the system clock
// Notes:   tick is a one-cycle enable pulse
`timescale 1ns/1ps
interface prescale_if;
	logic [1:0] scale;
	logic       tick;
	modport core    (output scale, input tick);
	modport divider (input scale, output tick);
endinterface : prescale_if

// *** hw/clock_prescaler.sv ***
// Purpose: divides the system clock into a prescaled enable pulse
// Assumes: scale may change at any time
// Notes:   a change of scale restarts the count
`timescale 1ns/1ps
module clock_prescaler (
	input  wire logic   clk,
	input  wire logic   arst_n,
	prescale_if.divider px
);
	logic [5:0] count;
	logic [1:0] last_scale;
	wire  [5:0] divisor;
	wire        wrap;

	// divisor per scale code
	assign divisor = (px.scale == 2'h0) ? tmr_pkg::DIV_CODE0 :
	                 (px.scale == 2'h1) ? tmr_pkg::DIV_CODE1 :
	                 (px.scale == 2'h2) ? tmr_pkg::DIV_CODE2 : tmr_pkg::DIV_CODE3;
	assign wrap    = (count == divisor - 6'h01);
	assign px.tick = wrap && (last_scale == px.scale);

	// free-running divider count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count      <= 6'h00;
			last_scale <= 2'h0;
		end else begin
			last_scale <= px.scale;
			count      <= (wrap || last_scale != px.scale) ? 6'h00 : count + 6'h01;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_div4_period: assert property ((px.tick && px.scale == 2'h1 ##1 px.scale == 2'h1 [*4])
		|-> px.tick && !$past(px.tick) && !$past(px.tick, 2) && !$past(px.tick, 3))
		else $error("divide-by-4 tick spacing wrong");
	chk_div12_gap: assert property ((px.tick && px.scale == 2'h0)
		|=> (!px.tick || px.scale != 2'h0) [*8])
		else $error("divide-by-12 tick came early");
endmodule : clock_prescaler

// *** hw/dual_timer_counter.sv ***
// Purpose: two counter/timers with four modes behind an APB register window
// Assumes: event and gate pins are asynchronous; vector acks come from the core clock
// Notes:   zero-wait APB slave; read data is captured in the setup cycle
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dual_timer_counter (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic        timer_zero_event_pin,
	input  wire logic        timer_one_event_pin,
	input  wire logic        gate_input_zero,
	input  wire logic        gate_input_one,
	input  wire logic        timer_zero_vector_ack,
	input  wire logic        timer_one_vector_ack,
	output wire logic        timer_zero_overflow_flag,
	output wire logic        timer_one_overflow_flag,
	output logic             timer_one_overflow_pulse
);
	logic [7:0] timer_run_overflow_control;
	logic [7:0] timer_mode_register;
	logic [7:0] clock_select_register;
	logic [7:0] external_input_config_register;
	logic [7:0] timer_zero_low_byte;
	logic [7:0] timer_zero_high_byte;
	logic [7:0] timer_one_low_byte;
	logic [7:0] timer_one_high_byte;
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [1:0] event_prev;
	logic [7:0] next_control;

	prescale_if px ();

	clock_prescaler u_prescaler (
		.clk    (clk),
		.arst_n (arst_n),
		.px     (px)
	);

	// named control fields
	wire tmr_pkg::timer_mode_t mode0 = tmr_pkg::timer_mode_t'(timer_mode_register[1:0]);
	wire tmr_pkg::timer_mode_t mode1 = tmr_pkg::timer_mode_t'(timer_mode_register[5:4]);
	wire split  = (mode0 == tmr_pkg::MODE_SPLIT);
	wire ct0    = timer_mode_register[tmr_pkg::CT0_BIT];
	wire ct1    = timer_mode_register[tmr_pkg::CT1_BIT];
	wire timer_zero_gate_bit  = timer_mode_register[tmr_pkg::TIMER_ZERO_GATE_BIT_BIT];
	wire gate1  = timer_mode_register[tmr_pkg::GATE1_BIT];
	wire tr0    = timer_run_overflow_control[tmr_pkg::TR0_BIT];
	wire tr1    = timer_run_overflow_control[tmr_pkg::TR1_BIT];
	wire t0_sys = clock_select_register[tmr_pkg::T0_CLK_BIT];
	wire t1_sys = clock_select_register[tmr_pkg::T1_CLK_BIT];
	wire pol0   = external_input_config_register[tmr_pkg::POL0_BIT];
	wire pol1   = external_input_config_register[tmr_pkg::POL1_BIT];
	assign px.scale = clock_select_register[tmr_pkg::SCALE_LSB +: 2];

	// pin synchronisers: bit 0/1 event pins, bit 2/3 gate pins
	wire [3:0] pin_raw = {gate_input_one, gate_input_zero,
	                      timer_one_event_pin, timer_zero_event_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	// previous event samples for edge detection
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			event_prev <= 2'h0;
		end else begin
			event_prev <= pin_sync[1:0];
		end
	end
	wire [1:0] ev_fall = event_prev & ~pin_sync[1:0];

	// clock source and run qualification per timer
	wire int_clk0 = t0_sys | px.tick;
	wire int_clk1 = t1_sys | px.tick;
	wire src0     = ct0 ? ev_fall[0] : int_clk0;
	wire src1     = (ct1 && !split) ? ev_fall[1] : int_clk1;
	wire gate_ok0 = !timer_zero_gate_bit || (pin_sync[2] == pol0);
	wire gate_ok1 = !gate1 || (pin_sync[3] == pol1);
	wire run0     = tr0 && gate_ok0;
	wire run1     = (mode1 != tmr_pkg::MODE_SPLIT) &&
	                (split || (tr1 && gate_ok1));
	wire inc0     = run0 && src0;
	wire inc1     = run1 && src1;
	wire inc_high = split && tr1 && int_clk0;

	// one count step for a timer in a given mode: {overflow, high, low}
	function automatic logic [16:0] count_step(input tmr_pkg::timer_mode_t m,
	                                           input logic [7:0] lo,
	                                           input logic [7:0] hi);
		logic [12:0] v13;
		logic [15:0] v16;
		v13 = {hi, lo[4:0]} + 13'h0001;
		v16 = {hi, lo} + 16'h0001;
		unique case (m)
			tmr_pkg::MODE_13BIT: begin
				count_step = {({hi, lo[4:0]} == 13'h1FFF), v13[12:5], lo[7:5], v13[4:0]};
			end
			tmr_pkg::MODE_16BIT: begin
				count_step = {({hi, lo} == 16'hFFFF), v16};
			end
			tmr_pkg::MODE_RELOAD8: begin
				count_step = {(lo == 8'hFF), hi, (lo == 8'hFF) ? hi : lo + 8'h01};
			end
			tmr_pkg::MODE_SPLIT: begin
				count_step = {(lo == 8'hFF), hi, lo + 8'h01};
			end
		endcase
	endfunction : count_step

	// per-timer step results, each mode field steering its own timer
	wire [16:0] step0 = count_step(mode0, timer_zero_low_byte, timer_zero_high_byte);
	wire [16:0] step1 = count_step(mode1, timer_one_low_byte, timer_one_high_byte);
	wire        ovf0  = inc0 && step0[16];
	wire        ovf1  = inc1 && step1[16];
	wire        ovf_h = inc_high && (timer_zero_high_byte == 8'hFF);
	wire        set_tf0 = ovf0;
	wire        set_tf1 = split ? ovf_h : ovf1;

	// APB decode: zero wait states, error on unmapped word
	wire access  = psel && penable;
	wire wr      = access && pwrite && pstrb[0];
	wire hit_ctl = (paddr == tmr_pkg::OFS_CONTROL);
	wire hit_mod = (paddr == tmr_pkg::OFS_MODE);
	wire hit_clk = (paddr == tmr_pkg::OFS_CLKSEL);
	wire hit_cfg = (paddr == tmr_pkg::OFS_INCFG);
	wire hit_l0  = (paddr == tmr_pkg::OFS_T0_LOW);
	wire hit_h0  = (paddr == tmr_pkg::OFS_T0_HIGH);
	wire hit_l1  = (paddr == tmr_pkg::OFS_T1_LOW);
	wire hit_h1  = (paddr == tmr_pkg::OFS_T1_HIGH);
	wire hit_any = hit_ctl | hit_mod | hit_clk | hit_cfg | hit_l0 | hit_h0 | hit_l1 | hit_h1;
	wire wr_ctl  = wr && hit_ctl;
	wire wr_l0   = wr && hit_l0;
	wire wr_h0   = wr && hit_h0;
	wire wr_l1   = wr && hit_l1;
	wire wr_h1   = wr && hit_h1;
	assign pready  = 1'b1;
	assign pslverr = access && !hit_any;

	// read selection
	wire [7:0] rsel = hit_ctl ? timer_run_overflow_control :
	                  hit_mod ? timer_mode_register :
	                  hit_clk ? clock_select_register :
	                  hit_cfg ? external_input_config_register :
	                  hit_l0  ? timer_zero_low_byte :
	                  hit_h0  ? timer_zero_high_byte :
	                  hit_l1  ? timer_one_low_byte :
	                  hit_h1  ? timer_one_high_byte : 8'h00;

	// control register: vector ack or software clears, hardware set wins
	always_comb begin
		next_control = wr_ctl ? pwdata[7:0] : timer_run_overflow_control;
		if (timer_zero_vector_ack) begin
			next_control[tmr_pkg::TF0_BIT] = 1'b0;
		end
		if (timer_one_vector_ack) begin
			next_control[tmr_pkg::TF1_BIT] = 1'b0;
		end
		if (set_tf0) begin
			next_control[tmr_pkg::TF0_BIT] = 1'b1;
		end
		if (set_tf1) begin
			next_control[tmr_pkg::TF1_BIT] = 1'b1;
		end
	end

	// configuration registers and read data capture
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_run_overflow_control     <= tmr_pkg::REG_RESET;
			timer_mode_register            <= tmr_pkg::REG_RESET;
			clock_select_register          <= tmr_pkg::REG_RESET;
			external_input_config_register <= tmr_pkg::REG_RESET;
			prdata                         <= 32'h0000_0000;
		end else begin
			timer_run_overflow_control <= next_control;
			if (wr && hit_mod) begin
				timer_mode_register <= pwdata[7:0];
			end
			if (wr && hit_clk) begin
				clock_select_register <= pwdata[7:0] & tmr_pkg::CLKSEL_MASK;
			end
			if (wr && hit_cfg) begin
				external_input_config_register <= pwdata[7:0] & tmr_pkg::INCFG_MASK;
			end
			if (psel && !penable) begin
				prdata <= {24'h00_0000, rsel};
			end
		end
	end

	// count registers: a software write wins over a count step
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_zero_low_byte      <= tmr_pkg::REG_RESET;
			timer_zero_high_byte     <= tmr_pkg::REG_RESET;
			timer_one_low_byte       <= tmr_pkg::REG_RESET;
			timer_one_high_byte      <= tmr_pkg::REG_RESET;
			timer_one_overflow_pulse <= 1'b0;
		end else begin
			timer_one_overflow_pulse <= ovf1;
			if (wr_l0) begin
				timer_zero_low_byte <= pwdata[7:0];
			end else if (inc0) begin
				timer_zero_low_byte <= step0[7:0];
			end
			if (wr_h0) begin
				timer_zero_high_byte <= pwdata[7:0];
			end else if (split) begin
				timer_zero_high_byte <= inc_high ? timer_zero_high_byte + 8'h01
				                                 : timer_zero_high_byte;
			end else if (inc0) begin
				timer_zero_high_byte <= step0[15:8];
			end
			if (wr_l1) begin
				timer_one_low_byte <= pwdata[7:0];
			end else if (inc1) begin
				timer_one_low_byte <= step1[7:0];
			end
			if (wr_h1) begin
				timer_one_high_byte <= pwdata[7:0];
			end else if (inc1) begin
				timer_one_high_byte <= step1[15:8];
			end
		end
	end

	assign timer_zero_overflow_flag = timer_run_overflow_control[tmr_pkg::TF0_BIT];
	assign timer_one_overflow_flag  = timer_run_overflow_control[tmr_pkg::TF1_BIT];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	wire no_wr0 = !wr_l0 && !wr_h0 && !wr_ctl;

	chk_wrap_13bit: assert property ((mode0 == tmr_pkg::MODE_13BIT && inc0 && no_wr0 &&
		timer_zero_high_byte == 8'hFF && timer_zero_low_byte[4:0] == 5'h1F)
		|=> timer_zero_high_byte == 8'h00 && timer_zero_low_byte[4:0] == 5'h00
		&& timer_zero_overflow_flag)
		else $error("13-bit wrap did not clear count and set flag");
	chk_carry_13bit: assert property ((mode0 == tmr_pkg::MODE_13BIT && inc0 && no_wr0 &&
		timer_zero_low_byte[4:0] == 5'h1F && timer_zero_high_byte != 8'hFF)
		|=> timer_zero_high_byte == $past(timer_zero_high_byte) + 8'h01)
		else $error("13-bit carry into high byte missing");
	chk_wrap_16bit: assert property ((mode0 == tmr_pkg::MODE_16BIT && inc0 && no_wr0 &&
		{timer_zero_high_byte, timer_zero_low_byte} == 16'hFFFF)
		|=> {timer_zero_high_byte, timer_zero_low_byte} == 16'h0000 && timer_zero_overflow_flag)
		else $error("16-bit wrap wrong");
	chk_reload_8bit: assert property ((mode1 == tmr_pkg::MODE_RELOAD8 && inc1 && !wr_l1 &&
		!wr_h1 && timer_one_low_byte == 8'hFF)
		|=> timer_one_low_byte == $past(timer_one_high_byte)
		&& $stable(timer_one_high_byte) && timer_one_overflow_pulse)
		else $error("auto-reload did not copy high byte");
	chk_halt_stable: assert property ((!run0 && !split && !wr_l0 && !wr_h0)
		|=> $stable(timer_zero_low_byte) && $stable(timer_zero_high_byte))
		else $error("timer zero moved while halted");
	chk_event_only: assert property ((ct0 && !ev_fall[0]) |-> !inc0)
		else $error("counter mode counted without a falling edge");
	chk_run_keeps: assert property (($rose(tr0) && !wr_l0 && !wr_h0)
		|-> $stable(timer_zero_low_byte) && $stable(timer_zero_high_byte))
		else $error("setting run altered the count");
	chk_split_high: assert property ((split && inc_high && !wr_h0 && !wr_ctl &&
		timer_zero_high_byte == 8'hFF) |=> timer_zero_high_byte == 8'h00 && timer_one_overflow_flag)
		else $error("split high byte overflow wrong");
	chk_split_no_tf1: assert property ((split && !ovf_h && !wr_ctl && !timer_one_overflow_flag)
		|=> !timer_one_overflow_flag)
		else $error("timer one set its flag in split mode");
	chk_mode3_stop: assert property ((mode1 == tmr_pkg::MODE_SPLIT) |-> !inc1 ##1 !timer_one_overflow_pulse)
		else $error("timer one counted in mode 3");
	chk_ack_clear: assert property ((timer_zero_vector_ack && !set_tf0) |=> !timer_zero_overflow_flag)
		else $error("vector ack did not clear flag");
	chk_sync_delay: assert property ((event_prev[0] && !pin_sync[0] && ct0 && run0) |-> inc0)
		else $error("synchronised falling edge not counted");
endmodule : dual_timer_counter

// *** tb/pin_model.sv ***
// Purpose: far-side model of the event and gate pins of the timer block
// Assumes: driven on the bench clock, each level held whole cycles
// Notes:   event pins idle high so that each pulse gives one falling edge
`timescale 1ns/1ps
module pin_model (
	input  wire logic clk,
	output logic      event_zero,
	output logic      event_one,
	output logic      gate_zero,
	output logic      gate_one
);
	// idle levels at time zero
	initial begin
		event_zero = 1'b1;
		event_one  = 1'b1;
		gate_zero  = 1'b0;
		gate_one   = 1'b0;
	end

	// each level stands hold clocks, never under two for the synchroniser
	task automatic pulses(input int n, input int hold);
		repeat (n) begin
			@(posedge clk);
			event_zero <= 1'b0;
			event_one  <= 1'b0;
			repeat (hold) @(posedge clk);
			event_zero <= 1'b1;
			event_one  <= 1'b1;
			repeat (hold - 1) @(posedge clk);
		end
	endtask : pulses

	// gate levels change just after an edge
	task automatic gate(input logic v);
		@(posedge clk);
		gate_zero <= v;
		gate_one  <= v;
	endtask : gate
endmodule : pin_model

// *** tb/dual_timer_counter_test.sv ***
// Purpose: self-checking bench for the dual counter/timer block
// Assumes: zero-wait APB slave, pins driven by pin_model
// Notes:   reads through rd queue their expected byte; a monitor compares on completion
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module dual_timer_counter_test;
	typedef struct {logic [7:0] e; logic [7:0] m; logic err;} note_t;
	typedef struct {logic [7:0] md, base, th, tl, run, fl, thm, the, tlm, tle;} case_t;
	logic        clk, arst_n, psel, penable, pwrite, ack0, ack1;
	logic [7:0]  paddr, rnd, q;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	wire         pready, pslverr, ev0, ev1, g0, g1, tf0, tf1, pulse1;
	note_t       notes[$];
	case_t       cases[6];
	int          failures = 0, num_checks = 0, cycles = 0, seed = 88895;
	int          pulse_count = 0, p0, exp_pulse;
	int          divs[3] = '{tmr_pkg::DIV_CODE0, tmr_pkg::DIV_CODE1, tmr_pkg::DIV_CODE2};

	dual_timer_counter u_dual_timer_counter (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_zero_event_pin(ev0),
		.timer_one_event_pin(ev1), .gate_input_zero(g0), .gate_input_one(g1),
		.timer_zero_vector_ack(ack0), .timer_one_vector_ack(ack1),
		.timer_zero_overflow_flag(tf0), .timer_one_overflow_flag(tf1),
		.timer_one_overflow_pulse(pulse1));
	pin_model u_pin_model (.clk(clk), .event_zero(ev0), .event_one(ev1), .gate_zero(g0),
		.gate_one(g1));

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	// counts timer one overflow pulses for the per-case check
	always @(posedge clk) pulse_count <= pulse_count + int'(pulse1 === 1'b1);

	// compares each completed read that has a queued note with the oldest note
	always @(posedge clk) if (psel && penable && pready && !pwrite && notes.size() > 0) begin
		if (notes[0].m != 8'h00) `CHK("read byte", notes[0].e, prdata[7:0] & notes[0].m)
		`CHK("slave error", notes[0].err, pslverr)
		void'(notes.pop_front());
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata[7:0];
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, e, m, input logic err = 1'b0);
		notes.push_back('{e, m, err});
		apb(1'b0, a, 8'h00);
	endtask : rd

	task automatic wait_flag(input logic one);
		int n;
		n = 0;
		while ((one ? tf1 : tf0) !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		`CHK("overflow flag", 1'b1, one ? tf1 : tf0)
	endtask : wait_flag

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h00000000; pstrb = 4'hF; ack0 = 1'b0; ack1 = 1'b0;
		// md base th tl run fl thm the tlm tle
		cases[0] = '{8'h00, 8'h10, 8'hFF, 8'h10, 8'h10, 8'h20, 8'hFF, 8'h00, 8'h00, 8'h00};
		cases[1] = '{8'h01, 8'h10, 8'hFF, 8'hF0, 8'h10, 8'h20, 8'hFF, 8'h00, 8'h00, 8'h00};
		// low byte preloaded before run
		cases[2] = '{8'h02, 8'h10, 8'hC0, 8'hF0, 8'h10, 8'h20, 8'hFF, 8'hC0, 8'hC0, 8'hC0};
		cases[3] = '{8'h10, 8'h18, 8'hFF, 8'hF0, 8'h40, 8'h80, 8'hFF, 8'h00, 8'h00, 8'h00};
		// split with timer one parked in mode 3
		cases[4] = '{8'h33, 8'h10, 8'hF0, 8'h00, 8'h40, 8'h80, 8'hF0, 8'h00, 8'hFF, 8'h00};
		// timer one auto-reload
		cases[5] = '{8'h20, 8'h18, 8'hC0, 8'hF0, 8'h40, 8'h80, 8'hFF, 8'hC0, 8'hC0, 8'hC0};
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 32; a += 4) rd(8'(a), 8'h00, 8'hFF);
		rd(8'h20, 8'h00, 8'hFF, 1'b1);
		rnd = 8'($random(seed));
		wr(tmr_pkg::OFS_T1_HIGH, rnd);
		pstrb <= 4'h0;
		wr(tmr_pkg::OFS_T1_HIGH, ~rnd);
		pstrb <= 4'hF;
		rd(tmr_pkg::OFS_T1_HIGH, rnd, 8'hFF);
		$display("test registers done");
		foreach (cases[i]) begin
			p0 = pulse_count;
			wr(tmr_pkg::OFS_CONTROL, 8'h00);
			wr(tmr_pkg::OFS_MODE, cases[i].md);
			wr(tmr_pkg::OFS_CLKSEL, 8'h18);
			wr(cases[i].base, cases[i].tl);
			wr(cases[i].base + 8'h04, cases[i].th);
			wr(tmr_pkg::OFS_CONTROL, cases[i].run);
			wait_flag(cases[i].fl[7]);
			rd(tmr_pkg::OFS_CONTROL, cases[i].fl, cases[i].fl);
			// vector acks clear the raised flag
			@(posedge clk) {ack1, ack0} <= {cases[i].fl[7], cases[i].fl[5]};
			@(posedge clk) {ack1, ack0} <= 2'b00;
			rd(tmr_pkg::OFS_CONTROL, 8'h00, cases[i].fl);
			wr(tmr_pkg::OFS_CONTROL, 8'h00);
			rd(cases[i].base + 8'h04, cases[i].the, cases[i].thm);
			rd(cases[i].base, cases[i].tle, cases[i].tlm);
			// timer one pulses on its own wrap, never for the split high byte
			exp_pulse = int'(cases[i].fl[7] && cases[i].md[1:0] != 2'h3);
			`CHK("timer one pulses", exp_pulse, pulse_count - p0)
			$display("test wrap case %0d done", i);
		end
		wr(tmr_pkg::OFS_MODE, 8'h05);
		wr(tmr_pkg::OFS_T0_LOW, 8'h00);
		wr(tmr_pkg::OFS_T0_HIGH, 8'h00);
		wr(tmr_pkg::OFS_CONTROL, 8'h10);
		u_pin_model.pulses(5, 2 + int'($unsigned($random(seed)) % 3));
		repeat (4) @(posedge clk);
		rd(tmr_pkg::OFS_T0_LOW, 8'h05, 8'hFF);
		$display("test event count done");
		wr(tmr_pkg::OFS_CONTROL, 8'h00);
		wr(tmr_pkg::OFS_MODE, 8'h09);
		wr(tmr_pkg::OFS_INCFG, 8'h01);
		wr(tmr_pkg::OFS_T0_LOW, 8'hF0);
		wr(tmr_pkg::OFS_T0_HIGH, 8'hFF);
		wr(tmr_pkg::OFS_CONTROL, 8'h10);
		repeat (30) @(posedge clk);
		rd(tmr_pkg::OFS_T0_LOW, 8'hF0, 8'hFF);
		u_pin_model.gate(1'b1);
		wait_flag(1'b0);
		rd(tmr_pkg::OFS_CONTROL, 8'h30, 8'h30);
		@(posedge clk) ack0 <= 1'b1;
		@(posedge clk) ack0 <= 1'b0;
		rd(tmr_pkg::OFS_CONTROL, 8'h10, 8'h30);
		$display("test gate and ack done");
		for (int c = 0; c < 3; c++) begin
			wr(tmr_pkg::OFS_CONTROL, 8'h00);
			wr(tmr_pkg::OFS_MODE, 8'h01);
			wr(tmr_pkg::OFS_CLKSEL, 8'(c));
			wr(tmr_pkg::OFS_T0_LOW, 8'h00);
			wr(tmr_pkg::OFS_CONTROL, 8'h10);
			repeat (4 * divs[c]) @(posedge clk);
			wr(tmr_pkg::OFS_CONTROL, 8'h00);
			apb(1'b0, tmr_pkg::OFS_T0_LOW, 8'h00);
			`CHK("prescaled count", 1'b1, q >= 8'h03 && q <= 8'h05)
		end
		$display("test prescaler done");
		summarize();
	end
endmodule : dual_timer_counter_test
